/* fqr_defs.svh */
`ifndef FQR_DEFS_SVH
`define FQR_DEFS_SVH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define FQR_OP_QUAD_READ 8'h6b
`define FQR_OP_WR1_BUF1 8'h84
`define FQR_OP_WR1_BUF2 8'h87
`define FQR_OP_WR2_BUF1 8'h24
`define FQR_OP_WR2_BUF2 8'h27
`define FQR_OP_WR4_BUF1 8'h44
`define FQR_OP_WR4_BUF2 8'h47
`define FQR_OP_PROG_BUF1 8'h83
`define FQR_OP_PROG_BUF2 8'h86

// ****************************************************************
// Frame layout and page geometry
// ****************************************************************
`define FQR_OPC_LAST 5'h07
`define FQR_ADDR_LAST 5'h17
`define FQR_DUMMY_LAST 5'h07
`define FQR_LAST_BYTE_528 10'h20f
`define FQR_LAST_BYTE_512 10'h1ff
`define FQR_BYTE_BITS 4'h8
`define FQR_ERASED_BYTE 8'hff

// ****************************************************************
// Timing
// ****************************************************************
`define FQR_CORE_CLK_MHZ 100
`define FQR_ERASE_PROGRAM_TIME_NS 1000000

`endif

/* fqr_pkg.sv */
package fqr_pkg;

	// Serial frame phases
	typedef enum logic [2:0] {
		FQR_PH_OPC = 3'b000,
		FQR_PH_ADDR = 3'b001,
		FQR_PH_DUMMY = 3'b010,
		FQR_PH_RDATA = 3'b011,
		FQR_PH_WDATA = 3'b100,
		FQR_PH_IGNORE = 3'b101
	} fqr_phase_t;

	// Decoded command kinds
	typedef enum logic [2:0] {
		FQR_CMD_NONE = 3'b000,
		FQR_CMD_QREAD = 3'b001,
		FQR_CMD_WR1 = 3'b010,
		FQR_CMD_WR2 = 3'b011,
		FQR_CMD_WR4 = 3'b100,
		FQR_CMD_PROG = 3'b101
	} fqr_cmd_t;

	// Erase and program engine states
	typedef enum logic [1:0] {
		FQR_EP_IDLE = 2'b00,
		FQR_EP_ERASE = 2'b01,
		FQR_EP_PROG = 2'b10,
		FQR_EP_WAIT = 2'b11
	} fqr_ep_state_t;

	// Main array location
	typedef struct packed {
		logic [12:0] page;
		logic [9:0] byte_ofs;
	} fqr_loc_t;

endpackage : fqr_pkg

/* fqr_flash_cmd.sv */
`timescale 1ns/1ps
`include "fqr_defs.svh"
module fqr_flash_cmd #(
	parameter int ERASE_PROGRAM_TIME_NS = `FQR_ERASE_PROGRAM_TIME_NS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	input wire logic quad_enable_bit,
	input wire logic page_size_512,
	output fqr_pkg::fqr_loc_t arr_rd_loc,
	input wire logic [7:0] arr_rd_data,
	output fqr_pkg::fqr_loc_t arr_wr_loc,
	output logic [7:0] arr_wr_data,
	output logic arr_wr_en,
	input wire logic arr_wr_ok,
	output logic ready_busy,
	output logic erase_program_error_flag
);
	import fqr_pkg::*;

	// ****************************************************************
	// Constants
	// ****************************************************************
	localparam longint EP_CYCLES_RAW = (longint'(ERASE_PROGRAM_TIME_NS) *
		`FQR_CORE_CLK_MHZ) / 1000;
	localparam logic [31:0] EP_CYCLES = (EP_CYCLES_RAW < 1) ? 32'h1 :
		32'(EP_CYCLES_RAW);

	// ****************************************************************
	// Link side storage and state
	// ****************************************************************
	logic [7:0] buf_mem [0:1][0:527];
	logic frame_rst;
	fqr_phase_t phase_reg;
	fqr_cmd_t cmd_reg;
	logic [4:0] cnt_reg;
	logic [22:0] sh_reg;
	logic sel_reg;
	fqr_loc_t rd_loc_reg;
	logic half_reg;
	logic [9:0] wptr_reg;
	logic [7:0] wbyte_reg;
	logic [3:0] wbit_reg;
	logic qe_s1_reg;
	logic qe_s2_reg;
	logic psz_s1_reg;
	logic psz_s2_reg;
	logic arm_reg;
	logic [12:0] prog_page_reg;
	logic prog_sel_reg;
	logic tog_reg;
	logic [7:0] opc_full;
	logic [23:0] addr_full;
	logic [9:0] last_byte;
	logic [7:0] wbyte_next;
	logic [3:0] wbit_next;

	// Chip select high holds the frame logic clear, so no sck edge is needed to end a frame
	assign frame_rst = rst | cs_n;
	assign opc_full = {sh_reg[6:0], io_in[0]};
	assign addr_full = {sh_reg, io_in[0]};
	assign last_byte = psz_s2_reg ? `FQR_LAST_BYTE_512 : `FQR_LAST_BYTE_528;
	assign arr_rd_loc = rd_loc_reg;

	// Configuration levels come from the core domain, so two flops on the link clock
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			qe_s1_reg <= 1'b0;
			qe_s2_reg <= 1'b0;
			psz_s1_reg <= 1'b0;
			psz_s2_reg <= 1'b0;
		end else begin
			qe_s1_reg <= quad_enable_bit;
			qe_s2_reg <= qe_s1_reg;
			psz_s1_reg <= page_size_512;
			psz_s2_reg <= psz_s1_reg;
		end
	end

	// Incoming data gathered into a byte, width set by the command
	always_comb begin
		wbyte_next = wbyte_reg;
		wbit_next = wbit_reg;
		case (cmd_reg)
			FQR_CMD_WR1: begin
				wbyte_next = {wbyte_reg[6:0], io_in[0]};
				wbit_next = wbit_reg + 4'h1;
			end
			FQR_CMD_WR2: begin
				wbyte_next = {wbyte_reg[5:0], io_in[1:0]};
				wbit_next = wbit_reg + 4'h2;
			end
			FQR_CMD_WR4: begin
				wbyte_next = {wbyte_reg[3:0], io_in[3:0]};
				wbit_next = wbit_reg + 4'h4;
			end
			default: wbit_next = wbit_reg;
		endcase
	end

	// ****************************************************************
	// Frame sequencer, sampled on the rising link clock
	// ****************************************************************
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			phase_reg <= FQR_PH_OPC;
			cmd_reg <= FQR_CMD_NONE;
			cnt_reg <= 5'h00;
			sh_reg <= 23'h000000;
			sel_reg <= 1'b0;
			rd_loc_reg <= '0;
			half_reg <= 1'b0;
			wptr_reg <= 10'h000;
			wbyte_reg <= 8'h00;
			wbit_reg <= 4'h0;
		end else begin
			case (phase_reg)
				FQR_PH_OPC: begin
					sh_reg <= {sh_reg[21:0], io_in[0]};
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == `FQR_OPC_LAST) begin
						cnt_reg <= 5'h00;
						phase_reg <= FQR_PH_ADDR;
						sel_reg <= opc_full[0] & opc_full[1];
						case (opc_full)
							`FQR_OP_QUAD_READ: begin
								// Quad commands refused while quad mode is off
								cmd_reg <= qe_s2_reg ? FQR_CMD_QREAD : FQR_CMD_NONE;
								if (!qe_s2_reg) begin
									phase_reg <= FQR_PH_IGNORE;
								end
							end
							`FQR_OP_WR1_BUF1, `FQR_OP_WR1_BUF2: begin
								cmd_reg <= FQR_CMD_WR1;
							end
							`FQR_OP_WR2_BUF1, `FQR_OP_WR2_BUF2: begin
								cmd_reg <= FQR_CMD_WR2;
							end
							`FQR_OP_WR4_BUF1, `FQR_OP_WR4_BUF2: begin
								cmd_reg <= qe_s2_reg ? FQR_CMD_WR4 : FQR_CMD_NONE;
								if (!qe_s2_reg) begin
									phase_reg <= FQR_PH_IGNORE;
								end
							end
							`FQR_OP_PROG_BUF1, `FQR_OP_PROG_BUF2: begin
								cmd_reg <= FQR_CMD_PROG;
								sel_reg <= (opc_full == `FQR_OP_PROG_BUF2); // Not the write pattern
							end
							default: begin
								cmd_reg <= FQR_CMD_NONE;
								phase_reg <= FQR_PH_IGNORE;
							end
						endcase
					end
				end
				FQR_PH_ADDR: begin
					sh_reg <= addr_full[22:0];
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == `FQR_ADDR_LAST) begin
						cnt_reg <= 5'h00;
						// Page bits and offset bits sit differently per page size
						if (psz_s2_reg) begin
							rd_loc_reg.page <= addr_full[21:9];
							rd_loc_reg.byte_ofs <= {1'b0, addr_full[8:0]};
							wptr_reg <= {1'b0, addr_full[8:0]};
						end else begin
							rd_loc_reg.page <= addr_full[22:10];
							rd_loc_reg.byte_ofs <= addr_full[9:0];
							wptr_reg <= addr_full[9:0];
						end
						case (cmd_reg)
							FQR_CMD_QREAD: phase_reg <= FQR_PH_DUMMY;
							FQR_CMD_PROG: phase_reg <= FQR_PH_IGNORE;
							default: phase_reg <= FQR_PH_WDATA;
						endcase
					end
				end
				FQR_PH_DUMMY: begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == `FQR_DUMMY_LAST) begin
						phase_reg <= FQR_PH_RDATA;
					end
				end
				FQR_PH_RDATA: begin
					// Two clocks per byte; step the location after the low nibble
					half_reg <= ~half_reg;
					if (half_reg) begin
						if (rd_loc_reg.byte_ofs == last_byte) begin
							rd_loc_reg.byte_ofs <= 10'h000;
							rd_loc_reg.page <= rd_loc_reg.page + 13'h0001;
						end else begin
							rd_loc_reg.byte_ofs <= rd_loc_reg.byte_ofs + 10'h001;
						end
					end
				end
				FQR_PH_WDATA: begin
					wbyte_reg <= wbyte_next;
					wbit_reg <= wbit_next;
					if (wbit_next == `FQR_BYTE_BITS) begin
						wbit_reg <= 4'h0;
						wptr_reg <= (wptr_reg == last_byte) ? 10'h000 :
							wptr_reg + 10'h001;
					end
				end
				FQR_PH_IGNORE: cnt_reg <= 5'h00;
				default: phase_reg <= FQR_PH_IGNORE;
			endcase
		end
	end

	// Buffer store; only buffer writes reach it, quad reads never touch it
	always_ff @(posedge sck) begin
		if (!cs_n && phase_reg == FQR_PH_WDATA && wbit_next == `FQR_BYTE_BITS) begin
			buf_mem[sel_reg][wptr_reg] <= wbyte_next;
		end
	end

	// ****************************************************************
	// Data line drive, changed on the falling link clock
	// ****************************************************************
	// Host samples on the rising edge, so the device moves on the falling one
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			io_out <= 4'h0;
			io_oe_n <= 4'hf;
		end else if (phase_reg == FQR_PH_RDATA) begin
			io_oe_n <= 4'h0;
			io_out <= half_reg ? arr_rd_data[3:0] : arr_rd_data[7:4];
		end else begin
			io_oe_n <= 4'hf;
			io_out <= 4'h0;
		end
	end

	// ****************************************************************
	// Program request handed from the frame to the core
	// ****************************************************************
	// Arm at the end of the program address; a fresh frame disarms on its first edge
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			arm_reg <= 1'b0;
			prog_page_reg <= 13'h0000;
			prog_sel_reg <= 1'b0;
		end else if (!cs_n && phase_reg == FQR_PH_OPC && cnt_reg == 5'h00) begin
			arm_reg <= 1'b0;
		end else if (!cs_n && phase_reg == FQR_PH_ADDR && cnt_reg == `FQR_ADDR_LAST &&
			cmd_reg == FQR_CMD_PROG) begin
			arm_reg <= 1'b1;
			prog_sel_reg <= sel_reg;
			prog_page_reg <= psz_s2_reg ? addr_full[21:9] : addr_full[22:10];
		end
	end

	// The clock stops after the frame, so the rising chip select itself flips the toggle
	always_ff @(posedge cs_n or posedge rst) begin
		if (rst) begin
			tog_reg <= 1'b0;
		end else if (arm_reg) begin
			tog_reg <= ~tog_reg;
		end
	end

	// ****************************************************************
	// Erase and program engine, core clock
	// ****************************************************************
	fqr_ep_state_t st_reg;
	logic tog_s1_reg;
	logic tog_s2_reg;
	logic tog_seen_reg;
	logic [12:0] page_reg;
	logic bsel_reg;
	logic [9:0] idx_reg;
	logic [31:0] timer_reg;
	logic err_reg;
	logic [9:0] core_last;
	logic start;

	assign core_last = page_size_512 ? `FQR_LAST_BYTE_512 : `FQR_LAST_BYTE_528;
	assign start = (st_reg == FQR_EP_IDLE) && (tog_s2_reg != tog_seen_reg);

	// Toggle synchroniser; the first flop feeds only the second
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
		end else begin
			tog_s1_reg <= tog_reg;
			tog_s2_reg <= tog_s1_reg;
		end
	end

	// Sequence: erase every byte to ones, copy the buffer, pad to the full time
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg <= FQR_EP_IDLE;
			tog_seen_reg <= 1'b0;
			page_reg <= 13'h0000;
			bsel_reg <= 1'b0;
			idx_reg <= 10'h000;
			timer_reg <= 32'h0;
		end else begin
			timer_reg <= timer_reg + 32'h1;
			case (st_reg)
				FQR_EP_IDLE: begin
					if (start) begin
						// Page and buffer words were held still since the frame ended
						tog_seen_reg <= tog_s2_reg;
						page_reg <= prog_page_reg;
						bsel_reg <= prog_sel_reg;
						idx_reg <= 10'h000;
						timer_reg <= 32'h1;
						st_reg <= FQR_EP_ERASE;
					end
				end
				FQR_EP_ERASE: begin
					idx_reg <= (idx_reg == core_last) ? 10'h000 : idx_reg + 10'h001;
					if (idx_reg == core_last) begin
						st_reg <= FQR_EP_PROG;
					end
				end
				FQR_EP_PROG: begin
					idx_reg <= idx_reg + 10'h001;
					if (idx_reg == core_last) begin
						st_reg <= FQR_EP_WAIT;
					end
				end
				FQR_EP_WAIT: begin
					st_reg <= (timer_reg >= EP_CYCLES) ? FQR_EP_IDLE : FQR_EP_WAIT;
				end
				default: st_reg <= FQR_EP_IDLE;
			endcase
		end
	end

	// Array write port; buffer read across domains is safe as the host waits for ready
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arr_wr_en <= 1'b0;
			arr_wr_loc <= '0;
			arr_wr_data <= 8'h00;
		end else begin
			arr_wr_en <= (st_reg == FQR_EP_ERASE) || (st_reg == FQR_EP_PROG);
			arr_wr_loc <= {page_reg, idx_reg};
			arr_wr_data <= (st_reg == FQR_EP_ERASE) ? `FQR_ERASED_BYTE :
				buf_mem[bsel_reg][idx_reg];
		end
	end

	// Error is cleared by a new sequence and set by any failed byte; set wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			err_reg <= 1'b0;
		end else if (arr_wr_en && !arr_wr_ok) begin
			err_reg <= 1'b1;
		end else if (start) begin
			err_reg <= 1'b0;
		end
	end

	// Status outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ready_busy <= 1'b1;
			erase_program_error_flag <= 1'b0;
		end else begin
			ready_busy <= (st_reg == FQR_EP_IDLE) && !start;
			erase_program_error_flag <= err_reg;
		end
	end

endmodule : fqr_flash_cmd

/* fqr_flash_cmd_checker.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module fqr_flash_cmd_checker import fqr_pkg::*; #(
	parameter int ERASE_PROGRAM_TIME_NS = 1000000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic [3:0] io_oe_n,
	input wire logic quad_enable_bit,
	input fqr_pkg::fqr_loc_t arr_wr_loc,
	input logic [7:0] arr_wr_data,
	input logic arr_wr_en,
	input wire logic arr_wr_ok,
	input logic ready_busy,
	input logic erase_program_error_flag
);
	localparam int BUSY_MAX = ERASE_PROGRAM_TIME_NS / 10 + 1200;
	logic [7:0] qe_low_reg;
	logic [20:0] busy_reg;
	// Quad enable low time; saturates so it never wraps
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) qe_low_reg <= 8'h00;
		else if (quad_enable_bit) qe_low_reg <= 8'h00;
		else if (qe_low_reg != 8'hff) qe_low_reg <= qe_low_reg + 8'h01;
	end
	// Busy spell length, bounds the self-timed sequence
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) busy_reg <= 21'h0;
		else busy_reg <= ready_busy ? 21'h0 : busy_reg + 21'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_IDLE_RELEASE: assert property (cs_n |-> io_oe_n == 4'hf)
		else $error("lines driven outside a frame");
	AST_LINES_TOGETHER: assert property (io_oe_n == 4'h0 || io_oe_n == 4'hf)
		else $error("data lines not driven together");
	AST_QE_GATE: assert property (qe_low_reg == 8'hff |-> io_oe_n == 4'hf)
		else $error("quad read without quad enable");
	AST_BUSY_WRITING: assert property (arr_wr_en |-> !ready_busy)
		else $error("array written while ready");
	AST_ERASE_FIRST: assert property ($rose(arr_wr_en) |->
		arr_wr_data == 8'hff && arr_wr_loc.byte_ofs == 10'h000)
		else $error("sequence does not start with erase");
	AST_WR_RUN: assert property ($rose(arr_wr_en) |-> arr_wr_en [*8])
		else $error("write pass too short");
	AST_OFS_STEP: assert property (arr_wr_en && $past(arr_wr_en) |->
		arr_wr_loc.byte_ofs == $past(arr_wr_loc.byte_ofs) + 10'h001
		|| arr_wr_loc.byte_ofs == 10'h000)
		else $error("write offset skipped");
	AST_PAGE_HELD: assert property (arr_wr_en && $past(arr_wr_en) |->
		$stable(arr_wr_loc.page))
		else $error("page moved during sequence");
	// Failure is latched internally first, then registered onto the flag
	AST_ERR_SETS: assert property (arr_wr_en && !arr_wr_ok |->
		##2 erase_program_error_flag)
		else $error("failed byte not flagged");
	AST_ERR_CLEAR: assert property ($fell(erase_program_error_flag) |->
		##[0:3] !ready_busy)
		else $error("error flag cleared outside a start");
	AST_BUSY_BOUND: assert property (int'(busy_reg) < BUSY_MAX)
		else $error("busy too long");
endmodule : fqr_flash_cmd_checker

bind fqr_flash_cmd fqr_flash_cmd_checker #(.ERASE_PROGRAM_TIME_NS(ERASE_PROGRAM_TIME_NS)) u_chk (
	.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .io_oe_n(io_oe_n),
	.quad_enable_bit(quad_enable_bit), .arr_wr_loc(arr_wr_loc), .arr_wr_data(arr_wr_data),
	.arr_wr_en(arr_wr_en), .arr_wr_ok(arr_wr_ok), .ready_busy(ready_busy),
	.erase_program_error_flag(erase_program_error_flag));

/* fqr_host_model.sv */
`timescale 1ns/1ps
// ****
// Host controller model, mode 0
// ****
module fqr_host_model (
	output logic sck,
	output logic cs_n,
	output logic [3:0] h_dat,
	output logic h_en,
	input wire logic [3:0] io
);
	// Serial clock stands low between frames
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		h_dat = 4'hf;
		h_en = 1'b0;
	end
	// Data set while low, sampled on the rise
	task automatic clk(input logic [3:0] d, output logic [3:0] q);
		h_dat = d;
		#40;
		sck = 1'b1;
		q = io;
		#40;
		sck = 1'b0;
	endtask : clk
	// One byte, MSB first, w bits per clock
	task automatic put(input logic [7:0] v, input int w);
		logic [3:0] q;
		for (int i = 0; i < 8 / w; i++) begin
			clk(w == 4 ? v[7:4] : w == 2 ? {2'b11, v[7:6]} : {3'b111, v[7]}, q);
			v = v << w;
		end
	endtask : put
	// Opcode and three address bytes on the serial input
	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		h_en = 1'b1;
		#17;
		cs_n = 1'b0;
		put(op, 1);
		put(a[23:16], 1);
		put(a[15:8], 1);
		put(a[7:0], 1);
	endtask : cmd
	// Lines released so the device may drive them
	task automatic rd(output logic [7:0] b);
		logic [3:0] hi;
		logic [3:0] lo;
		h_en = 1'b0;
		clk(4'hf, hi);
		clk(4'hf, lo);
		b = {hi, lo};
	endtask : rd
	// End of frame with a gap after it
	task automatic stop();
		#23;
		cs_n = 1'b1;
		h_en = 1'b0;
		#60;
	endtask : stop
endmodule : fqr_host_model

/* fqr_flash_cmd_tb.sv */
`timescale 1ns/1ps
// ****
// Bench for the flash command block
// ****
module fqr_flash_cmd_tb;
	import fqr_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic qe = 1'b1;
	logic p512 = 1'b0;
	logic wr_ok = 1'b1;
	logic sck, cs_n, h_en, arr_wr_en, ready_busy, ep_err;
	logic [3:0] io, io_out, io_oe_n, h_dat;
	logic [7:0] rd_data, wr_data;
	logic [7:0] got_pg [528];
	logic [7:0] exp_buf [2][528];
	bit mark [2][528];
	logic [12:0] wpage;
	fqr_loc_t rd_loc, wr_loc;
	logic [31:0] seed = 32'h3198;
	int err_count, checks_done, wcnt, ebad, psz;
	int fail_at = -1;
	always #5 core_clk = ~core_clk;
	// Pull-ups on lines nobody drives
	assign io = (~io_oe_n & io_out) | (io_oe_n & (h_en ? h_dat : 4'hf));
	assign rd_data = rdv(rd_loc.page, rd_loc.byte_ofs);
	fqr_flash_cmd #(.ERASE_PROGRAM_TIME_NS(20000)) dut (.core_clk(core_clk), .rst(rst),
		.sck(sck), .cs_n(cs_n), .io_in(io), .io_out(io_out), .io_oe_n(io_oe_n),
		.quad_enable_bit(qe), .page_size_512(p512), .arr_rd_loc(rd_loc),
		.arr_rd_data(rd_data), .arr_wr_loc(wr_loc), .arr_wr_data(wr_data),
		.arr_wr_en(arr_wr_en), .arr_wr_ok(wr_ok), .ready_busy(ready_busy),
		.erase_program_error_flag(ep_err));
	fqr_host_model host (.sck(sck), .cs_n(cs_n), .h_dat(h_dat), .h_en(h_en), .io(io));
	// Log array writes; verify fails once when fail_at is hit
	always @(posedge core_clk) begin
		if (arr_wr_en) begin
			if (wcnt < psz && wr_data !== 8'hff) ebad++;
			if (wcnt >= psz) got_pg[wr_loc.byte_ofs] = wr_data;
			wpage = wr_loc.page;
			wcnt++;
		end
		wr_ok <= wcnt != fail_at;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Array content model, a hash of the location
	function automatic logic [7:0] rdv(input logic [12:0] p, input logic [9:0] o);
		return p[7:0] ^ o[7:0] ^ {o[9:8], p[12:7]};
	endfunction : rdv
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Load n random bytes; don't-care address bits random
	task automatic bwrite(input logic [7:0] op, input int ofs, input int n, input int w);
		int b;
		int sz;
		logic [7:0] d;
		b = int'(op[1:0] == 2'b11);
		sz = p512 ? 512 : 528;
		host.cmd(op, p512 ? {15'(rnd()), 9'(ofs)} : {14'(rnd()), 10'(ofs)});
		for (int i = 0; i < n; i++) begin
			d = 8'(rnd());
			host.put(d, w);
			exp_buf[b][(ofs + i) % sz] = d;
			mark[b][(ofs + i) % sz] = 1'b1;
		end
		host.stop();
	endtask : bwrite
	// Start a program and compare what reached the page
	task automatic prog(input logic [7:0] op, input logic [12:0] pg);
		int b;
		b = int'(op[1:0] == 2'b10);
		psz = p512 ? 512 : 528;
		wcnt = 0;
		ebad = 0;
		host.cmd(op, p512 ? {2'b00, pg, 9'(rnd())} : {1'b0, pg, 10'(rnd())});
		host.stop();
		for (int t = 0; t < 50 && ready_busy; t++) @(negedge core_clk);
		check("busy", ready_busy, 1'b0);
		for (int t = 0; t < 3000 && !ready_busy; t++) @(negedge core_clk);
		check("ready", ready_busy, 1'b1);
		check("writes", wcnt, 2 * psz);
		check("erase", ebad, 0);
		check("page", wpage, pg);
		for (int i = 0; i < psz; i++) begin
			if (mark[b][i]) check("byte", got_pg[i], exp_buf[b][i]);
		end
	endtask : prog
	// Quad read of n bytes; on = 0 expects no drive
	task automatic qread(input logic [23:0] a, input int n, input bit on);
		logic [7:0] d;
		logic [12:0] pg;
		logic [9:0] o;
		pg = p512 ? a[21:9] : a[22:10];
		o = p512 ? {1'b0, a[8:0]} : a[9:0];
		host.cmd(8'h6b, a);
		host.put(8'h00, 1);
		for (int i = 0; i < n; i++) begin
			host.rd(d);
			if (on) check("rdata", d, rdv(pg, o));
			else check("refused", io_oe_n, 4'hf);
			o = (o == (p512 ? 10'h1ff : 10'h20f)) ? 10'h000 : o + 10'h001;
			if (o == 10'h000) pg = pg + 13'h0001;
		end
		host.stop();
		check("release", io_oe_n, 4'hf);
	endtask : qread
	task automatic print_verdict();
		$display("Checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		bwrite(8'h84, 526, 4, 1);
		qread({1'b0, 13'h1fff, 10'h20e}, 4, 1);
		prog(8'h83, 13'(rnd()));
		bwrite(8'h27, 20, 6, 2);
		bwrite(8'h47, 526, 5, 4);
		fail_at = 7;
		prog(8'h86, 13'h1fff);
		check("err_set", ep_err, 1'b1);
		fail_at = -1;
		bwrite(8'h24, 300, 3, 2);
		bwrite(8'h44, 9, 3, 4);
		bwrite(8'h87, 0, 2, 1);
		prog(8'h83, 13'h0000);
		check("err_clr", ep_err, 1'b0);
		@(posedge core_clk);
		qe <= 1'b0;
		repeat (300) @(posedge core_clk);
		qread({1'b0, 13'(rnd()), 10'h005}, 2, 0);
		qe <= 1'b1;
		p512 <= 1'b1;
		mark = '{default: '0};
		repeat (300) @(posedge core_clk);
		qread({2'b00, 13'h0042, 9'h1fe}, 4, 1);
		bwrite(8'h44, 510, 4, 4);
		prog(8'h83, 13'h0abc);
		print_verdict();
	end
	// Watchdog for a hang
	initial begin
		#600000;
		err_count++;
		print_verdict();
	end
endmodule : fqr_flash_cmd_tb
